// ---- pmsr_pkg.sv ----
/*
 * shared constants, types and helpers for the transceiver mode and status
 * register bank. assumes a 10 MHz core clock and a byte-addressed bus whose
 * word index is the printed register index.
 */
package pmsr_pkg;

    // ==================================================================
    // bus geometry
    localparam int unsigned BUS_ADDR_W = 8;
    localparam int unsigned BUS_DATA_W = 32;
    localparam int unsigned REG_W      = 16;
    localparam int unsigned IDX_W      = 6;

    // ==================================================================
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MODE_CTRL     = 6'h11;
    localparam logic [IDX_W-1:0] IDX_SPECIAL_MODES = 6'h12;
    localparam logic [IDX_W-1:0] IDX_SYM_ERR       = 6'h1A;
    localparam logic [IDX_W-1:0] IDX_SPECIAL_CTRL  = 6'h1B;

    // ==================================================================
    // field positions
    localparam int unsigned MCS_EDPD_BIT    = 13;
    localparam int unsigned MCS_LOOP_BIT    = 9;
    localparam int unsigned MCS_ALT_BIT     = 6;
    localparam int unsigned MCS_ENERGY_BIT  = 1;
    localparam int unsigned MCS_SPARE_BIT   = 0;
    localparam int unsigned SM_HOST_BIT     = 14;
    localparam int unsigned SM_MODE_LSB     = 5;
    localparam int unsigned SM_ADDR_LSB     = 0;
    localparam int unsigned SCI_AUTODIS_BIT = 15;
    localparam int unsigned SCI_SWAP_BIT    = 13;
    localparam int unsigned SCI_POL_BIT     = 4;

    // ==================================================================
    // reset values
    localparam logic              RST_BIT    = 1'b0;
    localparam logic              RST_ENERGY = 1'b1;
    localparam logic [REG_W-1:0]  RST_SYMERR = 16'h0000;
    localparam logic [2:0]        RST_MODE   = 3'h0;
    localparam logic [4:0]        RST_ADDR   = 5'h00;

    // ==================================================================
    // timing
    localparam int unsigned ENERGY_TIMEOUT_MS     = 256;
    localparam int unsigned CLK_HZ                = 10_000_000;
    localparam int unsigned ENERGY_TIMEOUT_CYCLES = ENERGY_TIMEOUT_MS * (CLK_HZ / 1000);

    // ==================================================================
    // types
    typedef struct packed {
        logic       edpd;
        logic       loop;
        logic       alt_irq;
        logic       spare;
        logic       host_sel;
        logic [2:0] mode;
        logic [4:0] addr;
        logic       autodis;
        logic       swap_sel;
    } pmsr_cfg_t;

    typedef enum logic {
        PMSR_BUS_WAIT = 1'b0,
        PMSR_BUS_ACK  = 1'b1
    } pmsr_bus_st_t;

    // ==================================================================
    // helpers
    function automatic logic [IDX_W-1:0] reg_index(input logic [BUS_ADDR_W-1:0] a);
        reg_index = a[BUS_ADDR_W-1:2];
    endfunction : reg_index

    function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old_v,
                                                 input logic [REG_W-1:0] new_v,
                                                 input logic [1:0]       be);
        merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : merge16

endpackage : pmsr_pkg

// ---- pmsr_sync2.sv ----
/*
 * two flip-flop synchroniser for a bundle of slow levels.
 * assumes each bit changes rarely; no coherence between bits is promised.
 */
module pmsr_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             core_clk_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ==================================================================
    // stages, data path only so no reset
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge core_clk_in) begin
        meta_r <= async_in;
        sync_r <= meta_r;
    end

    assign sync_out = sync_r;

endmodule : pmsr_sync2

// ---- pmsr_energy_watch.sv ----
/*
 * line energy presence tracker with a silence timeout.
 * assumes energy_in is already synchronised to core_clk_in.
 * only the hardware reset touches it; the software reset does not reach here.
 */
module pmsr_energy_watch
    import pmsr_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = ENERGY_TIMEOUT_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic energy_in,
    output logic      present_out
);

    localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYCLES - 1);

    // ==================================================================
    // silence counter
    logic [CNT_W-1:0] quiet_r;
    logic             present_r;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            quiet_r   <= '0;
            present_r <= RST_ENERGY;
        end else if (energy_in) begin
            quiet_r   <= '0;
            present_r <= 1'b1;
        end else if (quiet_r == LAST) begin
            present_r <= 1'b0;
        end else begin
            quiet_r   <= quiet_r + CNT_W'(1);
        end
    end

    assign present_out = present_r;

endmodule : pmsr_energy_watch

// ---- pmsr_regs.sv ----
/*
 * vendor mode and status register bank of a 10/100 transceiver, reached
 * over an avalon-mm slave with waitrequest, plus the control outputs that
 * these registers steer. assumes the receive, link and crossover logic on
 * the same clock supply speed, symbol error, packet and polarity levels;
 * energy detect and the strap pins arrive asynchronously.
 */
// The Avalon-MM register port was chosen for this implementation.
// How it works
// - mode control bit 13 enables energy-detect power-down, reset value zero.
// - mode control bit 9 loops received packets back to line, 100 Mb only.
// - far loopback only acts in reduced-pin host mode, not in MII mode.
// - far loopback keeps working while the isolate control is set.
// - mode control bit 6 picks primary (0) or alternate (1) interrupts.
// - energy-present bit drops after 256 ms without valid line energy.
// - energy-present is one after hardware reset, kept through software reset.
// - special modes bit 14 picks MII (0) or reduced-pin (1) host interface.
// - special modes bits 7:5 hold operating mode, reset from mode straps.
// - station address bits 4:0 feed management match and scrambler seed.
// - station address resets from the address straps.
// - symbol error counter counts invalid 100 Mb symbols, idle ones too.
// - counter advances at most once per received packet.
// - counter runs through 16 bits and wraps to zero.
// - counter clears on reset, never on read.
// - counter holds still at 10 Mb.
// - special control bit 15 disables auto crossover when one.
// - with auto crossover off, bit 13 picks straight (0) or swapped (1).
// - special control bit 4 reports 10 Mb receive polarity reversed.
module pmsr_regs
    import pmsr_pkg::*;
#(
    parameter int unsigned ENERGY_CYCLES = ENERGY_TIMEOUT_CYCLES
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  soft_reset_in,
    input  wire logic [BUS_ADDR_W-1:0] avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [BUS_DATA_W-1:0] avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic      [BUS_DATA_W-1:0] avs_readdata_out,
    output logic                       avs_waitrequest_out,
    input  wire logic                  energy_detect_in,
    input  wire logic [2:0]            mode_strap_in,
    input  wire logic [4:0]            addr_strap_in,
    input  wire logic                  speed_100_in,
    input  wire logic                  isolate_in,
    input  wire logic                  sym_invalid_in,
    input  wire logic                  rx_packet_active_in,
    input  wire logic                  rx_polarity_reversed_in,
    input  wire logic                  auto_swap_in,
    output logic                       energy_detect_powerdown_out,
    output logic                       remote_loop_active_out,
    output logic                       alternate_irq_select_out,
    output logic                       energy_present_out,
    output logic                       host_interface_select_out,
    output logic      [2:0]            trans_mode_out,
    output logic      [4:0]            mgmt_address_out,
    output logic      [4:0]            scrambler_seed_out,
    output logic                       crossover_auto_enable_out,
    output logic                       pair_swap_out
);

    // ==================================================================
    // declarations
    pmsr_bus_st_t     bus_st_r;
    logic             wait_r;
    logic [31:0]      rdata_r;
    logic             commit_wr;
    logic             commit_rd;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] wdata16;
    logic [1:0]       be16;
    pmsr_cfg_t        cfg_r;
    logic [2:0]       mode_strap_r;
    logic             strap_load_r;
    logic [7:0]       strap_sync;
    logic             energy_sync;
    logic             energy_present;
    logic [REG_W-1:0] symerr_r;
    logic             counted_r;
    logic             sym_inc;
    logic             pol_r;
    logic [REG_W-1:0] rd_mode_ctrl;
    logic [REG_W-1:0] rd_special_modes;
    logic [REG_W-1:0] rd_special_ctrl;
    logic [REG_W-1:0] rd_word;
    logic [REG_W-1:0] wr_mode_ctrl;
    logic [REG_W-1:0] wr_special_modes;
    logic [REG_W-1:0] wr_special_ctrl;
    logic             loop_nxt;
    logic             swap_nxt;

    // ==================================================================
    // pin synchronisers
    pmsr_sync2 #(
        .WIDTH (9)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .async_in    ({energy_detect_in, mode_strap_in, addr_strap_in}),
        .sync_out    ({energy_sync, strap_sync})
    );

    // ==================================================================
    // energy presence
    pmsr_energy_watch #(
        .TIMEOUT_CYCLES (ENERGY_CYCLES)
    ) u_energy (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .energy_in   (energy_sync),
        .present_out (energy_present)
    );

    // ==================================================================
    // bus slave: waitrequest drops for one cycle, one cycle after request
    assign idx       = reg_index(avs_address_in);
    assign wdata16   = avs_writedata_in[REG_W-1:0];
    assign be16      = avs_byteenable_in[1:0];
    assign commit_wr = (bus_st_r == PMSR_BUS_ACK) && avs_write_in;
    assign commit_rd = (bus_st_r == PMSR_BUS_ACK) && avs_read_in;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            bus_st_r <= PMSR_BUS_WAIT;
            wait_r   <= 1'b1;
        end else begin
            unique case (bus_st_r)
                PMSR_BUS_WAIT: begin
                    if (avs_read_in || avs_write_in) begin
                        bus_st_r <= PMSR_BUS_ACK;
                        wait_r   <= 1'b0;
                    end
                end
                PMSR_BUS_ACK: begin
                    bus_st_r <= PMSR_BUS_WAIT;
                    wait_r   <= 1'b1;
                end
            endcase
        end
    end

    // ==================================================================
    // readback, reserved bits are constant zero
    assign rd_mode_ctrl = {2'b00, cfg_r.edpd, 3'b000, cfg_r.loop, 2'b00,
                           cfg_r.alt_irq, 4'h0, energy_present, cfg_r.spare};
    assign rd_special_modes = {1'b0, cfg_r.host_sel, 6'h00, cfg_r.mode, cfg_r.addr};
    assign rd_special_ctrl = {cfg_r.autodis, 1'b0, cfg_r.swap_sel, 8'h00,
                              pol_r, 4'h0};

    // merged write words; a bit cannot be picked straight off a function call
    assign wr_mode_ctrl     = merge16(rd_mode_ctrl, wdata16, be16);
    assign wr_special_modes = merge16(rd_special_modes, wdata16, be16);
    assign wr_special_ctrl  = merge16(rd_special_ctrl, wdata16, be16);

    always_comb begin
        unique case (idx)
            IDX_MODE_CTRL:     rd_word = rd_mode_ctrl;
            IDX_SPECIAL_MODES: rd_word = rd_special_modes;
            IDX_SYM_ERR:       rd_word = symerr_r;
            IDX_SPECIAL_CTRL:  rd_word = rd_special_ctrl;
            default:           rd_word = 16'h0000;
        endcase
    end

    // data is captured as waitrequest drops so it stands through the ack cycle
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rdata_r <= 32'h0000_0000;
        end else if (bus_st_r == PMSR_BUS_WAIT && avs_read_in) begin
            rdata_r <= {16'h0000, rd_word};
        end
    end

    // ==================================================================
    // mode control register
    always_ff @(posedge core_clk_in) begin
        if (rst_in || soft_reset_in) begin
            cfg_r.edpd    <= RST_BIT;
            cfg_r.loop    <= RST_BIT;
            cfg_r.alt_irq <= RST_BIT;
            cfg_r.spare   <= RST_BIT;
        end else if (commit_wr && idx == IDX_MODE_CTRL) begin
            cfg_r.edpd    <= wr_mode_ctrl[MCS_EDPD_BIT];
            cfg_r.loop    <= wr_mode_ctrl[MCS_LOOP_BIT];
            cfg_r.alt_irq <= wr_mode_ctrl[MCS_ALT_BIT];
            cfg_r.spare   <= wr_mode_ctrl[MCS_SPARE_BIT];
        end
    end

    // ==================================================================
    // straps: caught once on the first edge after hardware reset release
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            strap_load_r <= 1'b1;
            mode_strap_r <= RST_MODE;
        end else if (strap_load_r) begin
            strap_load_r <= 1'b0;
            mode_strap_r <= strap_sync[7:5];
        end
    end

    // ==================================================================
    // special modes register; the address survives a software reset
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cfg_r.host_sel <= RST_BIT;
            cfg_r.mode     <= RST_MODE;
            cfg_r.addr     <= RST_ADDR;
        end else if (strap_load_r) begin
            cfg_r.mode <= strap_sync[7:5];
            cfg_r.addr <= strap_sync[4:0];
        end else if (soft_reset_in) begin
            cfg_r.host_sel <= RST_BIT;
            cfg_r.mode     <= mode_strap_r;
        end else if (commit_wr && idx == IDX_SPECIAL_MODES) begin
            cfg_r.host_sel <= wr_special_modes[SM_HOST_BIT];
            cfg_r.mode     <= wr_special_modes[SM_MODE_LSB+:3];
            cfg_r.addr     <= wr_special_modes[SM_ADDR_LSB+:5];
        end
    end

    // ==================================================================
    // special control register
    always_ff @(posedge core_clk_in) begin
        if (rst_in || soft_reset_in) begin
            cfg_r.autodis  <= RST_BIT;
            cfg_r.swap_sel <= RST_BIT;
        end else if (commit_wr && idx == IDX_SPECIAL_CTRL) begin
            cfg_r.autodis  <= wr_special_ctrl[SCI_AUTODIS_BIT];
            cfg_r.swap_sel <= wr_special_ctrl[SCI_SWAP_BIT];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in || soft_reset_in) begin
            pol_r <= RST_BIT;
        end else begin
            pol_r <= rx_polarity_reversed_in;
        end
    end

    // ==================================================================
    // symbol error counter; outside a packet every bad idle symbol counts at 100 Mb, except in the first idle cycle after a counted packet
    assign sym_inc = speed_100_in && sym_invalid_in && !counted_r;

    always_ff @(posedge core_clk_in) begin
        if (rst_in || soft_reset_in) begin
            symerr_r <= RST_SYMERR;
        end else if (sym_inc) begin
            symerr_r <= symerr_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in || soft_reset_in || !rx_packet_active_in) begin
            counted_r <= 1'b0;
        end else if (sym_inc) begin
            counted_r <= 1'b1;
        end
    end

    // ==================================================================
    // control outputs; isolate is deliberately not part of the loop gate
    assign loop_nxt = cfg_r.loop && cfg_r.host_sel && speed_100_in;
    assign swap_nxt = cfg_r.autodis ? cfg_r.swap_sel : auto_swap_in;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            energy_detect_powerdown_out <= RST_BIT;
            remote_loop_active_out      <= RST_BIT;
            alternate_irq_select_out    <= RST_BIT;
            host_interface_select_out   <= RST_BIT;
            trans_mode_out              <= RST_MODE;
            mgmt_address_out            <= RST_ADDR;
            scrambler_seed_out          <= RST_ADDR;
            crossover_auto_enable_out   <= 1'b1;
            pair_swap_out               <= RST_BIT;
        end else begin
            energy_detect_powerdown_out <= cfg_r.edpd;
            remote_loop_active_out      <= loop_nxt;
            alternate_irq_select_out    <= cfg_r.alt_irq;
            host_interface_select_out   <= cfg_r.host_sel;
            trans_mode_out              <= cfg_r.mode;
            mgmt_address_out            <= cfg_r.addr;
            scrambler_seed_out          <= cfg_r.addr;
            crossover_auto_enable_out   <= !cfg_r.autodis;
            pair_swap_out               <= swap_nxt;
        end
    end

    assign avs_readdata_out    = rdata_r;
    assign avs_waitrequest_out = wait_r;
    assign energy_present_out  = energy_present;

    // ==================================================================
    // assertions
    a_loop_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
        remote_loop_active_out |-> $past(cfg_r.host_sel) && $past(speed_100_in))
        else $error("loopback active outside reduced-pin 100 Mb");

    a_loop_isolate: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (cfg_r.loop && cfg_r.host_sel && speed_100_in && isolate_in) |=> remote_loop_active_out)
        else $error("loopback blocked by isolate");

    a_energy_fall: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(energy_present) |-> !$past(energy_sync) && !$past(energy_sync, 2))
        else $error("energy-present dropped while energy seen");

    a_energy_hwrst: assert property (@(posedge core_clk_in)
        rst_in |=> energy_present)
        else $error("energy-present not set by hardware reset");

    a_energy_swrst: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (soft_reset_in && energy_present && energy_sync) |=> energy_present)
        else $error("software reset disturbed energy-present");

    a_sym_once: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (rx_packet_active_in && counted_r && !soft_reset_in) |=> $stable(symerr_r))
        else $error("counter advanced twice in one packet");

    a_sym_10m: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!speed_100_in && !soft_reset_in) |=> $stable(symerr_r))
        else $error("counter moved at 10 Mb");

    a_sym_wrap: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (symerr_r == 16'hFFFF && sym_inc && !soft_reset_in) |=> symerr_r == 16'h0000)
        else $error("counter did not wrap");

    a_sym_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (commit_rd && idx == IDX_SYM_ERR && !sym_inc && !soft_reset_in) |=> $stable(symerr_r))
        else $error("counter cleared by read");

    a_swap_manual: assert property (@(posedge core_clk_in) disable iff (rst_in)
        cfg_r.autodis |=> pair_swap_out == $past(cfg_r.swap_sel))
        else $error("manual pair select not applied");

    a_seed_match: assert property (@(posedge core_clk_in) disable iff (rst_in)
        scrambler_seed_out == mgmt_address_out ##1 mgmt_address_out == $past(cfg_r.addr))
        else $error("seed and address disagree");

    a_bus_answer: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ((avs_read_in || avs_write_in) && avs_waitrequest_out) |=> !avs_waitrequest_out ##1
        avs_waitrequest_out)
        else $error("bus answer not one cycle");

    c_loop_on: cover property (@(posedge core_clk_in) disable iff (rst_in)
        remote_loop_active_out);

    c_sym_wrap: cover property (@(posedge core_clk_in) disable iff (rst_in)
        symerr_r == 16'hFFFF ##1 symerr_r == 16'h0000);

    c_energy_drop: cover property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(energy_present));

    c_write_commit: cover property (@(posedge core_clk_in) disable iff (rst_in)
        commit_wr && idx == IDX_SPECIAL_CTRL);

endmodule : pmsr_regs

// ---- pmsr_line_model.sv ----
/* line side model: packets carrying invalid symbols, plus idle noise.
   assumes the core clock of the register bank. */
module pmsr_line_model (
    input  wire logic core_clk_in,
    input  wire logic go_in,
    input  wire logic noise_in,
    output logic      pkt_out,
    output logic      sym_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r = 4'h0;
    // ====================
    // packet framing
    always_ff @(posedge core_clk_in) begin
        if (go_in)
            cnt_r <= 4'hF;
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
    end
    assign pkt_out = (cnt_r != 4'h0);
    // several bad symbols per packet, so a per-symbol count shows up
    assign sym_out = noise_in | (pkt_out & cnt_r[0]);
endmodule : pmsr_line_model

// ---- phy_mode_status_regs_tb_top.sv ----
/* self-checking bench of the mode and status register bank.
   assumes a 10 MHz clock; line side comes from the packet model. */
module phy_mode_status_regs_tb_top;
    import pmsr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, srst = 1'b0, rd = 1'b0, wr = 1'b0, en = 1'b0, spd = 1'b1;
    logic iso = 1'b0, pol = 1'b0, asw = 1'b0, go = 1'b0, noise = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic wt, pk, sy, edpd, lp, alt, enp, hs, xa, sw;
    logic [2:0] tm;
    logic [4:0] ma, ss;
    logic [7:0] regs [3] = '{8'h44, 8'h48, 8'h6C};
    int err_total = 0;
    int num_checks = 0;
    pmsr_regs #(.ENERGY_CYCLES(20)) pmsr_regs_inst (.core_clk_in(clk), .rst_in(rst), .soft_reset_in(srst),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'h3), .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .energy_detect_in(en),
        .mode_strap_in(3'h5), .addr_strap_in(5'h0B), .speed_100_in(spd), .isolate_in(iso),
        .sym_invalid_in(sy), .rx_packet_active_in(pk), .rx_polarity_reversed_in(pol), .auto_swap_in(asw),
        .energy_detect_powerdown_out(edpd), .remote_loop_active_out(lp), .alternate_irq_select_out(alt),
        .energy_present_out(enp), .host_interface_select_out(hs), .trans_mode_out(tm),
        .mgmt_address_out(ma), .scrambler_seed_out(ss), .crossover_auto_enable_out(xa), .pair_swap_out(sw));
    pmsr_line_model pmsr_line_model_inst (.core_clk_in(clk), .go_in(go), .noise_in(noise), .pkt_out(pk),
        .sym_out(sy));
    initial forever #50 clk = ~clk;
    // ====================
    // tasks and expectations
    task automatic end_of_test;
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("FAIL %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {rd, wr, adr, wd} <= {!w, w, a, 16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 40);
        q = rdat;
        {rd, wr} <= 2'b00;
        if (wt !== 1'b0) begin
            err_total++;
            end_of_test();
        end
    endtask : bus
    function automatic logic [15:0] exp_val(input logic [7:0] a, input logic [15:0] d);
        case (a)
            8'h44: exp_val = (d & 16'h2241) | 16'h0002;
            8'h48: exp_val = d & 16'h40FF;
            8'h6C: exp_val = (d & 16'hA000) | {11'h000, pol, 4'h0};
            default: exp_val = 16'h0000;
        endcase
    endfunction : exp_val
    // ====================
    // main sequence
    initial begin
        logic [15:0] d;
        void'($urandom(32'h59d3));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(enp, 1);
        bus(0, 8'h44, 0); chk(q, 32'h0002);
        bus(0, 8'h48, 0); chk(q, 32'h00AB);
        chk({ma, ss}, 10'h16B);
        bus(0, 8'h6C, 0); chk(q, 0); chk(xa, 1);
        en <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            d = 16'($urandom);
            pol <= 1'($urandom);
            bus(1, regs[i % 3], d);
            bus(0, regs[i % 3], 0); chk(q, {16'h0, exp_val(regs[i % 3], d)});
        end
        bus(1, 8'h44, 16'h2240);
        iso <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            spd <= i[0];
            bus(1, 8'h48, {1'b0, i[1], 14'h00AB});
            repeat (3) @(posedge clk);
            chk(lp, i[0] & i[1]);
            chk({hs, tm}, {i[1], 3'h5});
        end
        chk({edpd, alt}, 2'b11);
        asw <= 1'($urandom);
        for (int i = 0; i < 3; i++) begin
            d = {i != 2, 1'b0, i == 0, 13'h0000};
            bus(1, 8'h6C, d);
            repeat (3) @(posedge clk);
            chk({xa, sw}, {!d[15], d[15] ? d[13] : asw});
        end
        for (int i = 0; i < 3; i++) begin
            spd <= (i != 2);
            @(posedge clk);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            repeat (20) @(posedge clk);
        end
        bus(0, 8'h68, 0); chk(q, 32'h0002);
        {spd, noise} <= 2'b11;
        repeat (65539) @(posedge clk);
        noise <= 1'b0;
        bus(0, 8'h68, 0); chk(q, 32'h0005);
        bus(1, 8'h68, 16'h1234); bus(0, 8'h68, 0); chk(q, 32'h0005);
        bus(0, 8'h00, 0); chk(q, 0);
        en <= 1'b0;
        repeat (30) @(posedge clk);
        bus(0, 8'h44, 0); chk({q[1], enp}, 2'b00);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(enp, 0);
        en <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        bus(0, 8'h68, 0); chk(q, 0); chk(enp, 1);
        end_of_test();
    end
endmodule : phy_mode_status_regs_tb_top
